// ---- hdl/prmc_pkg.sv ----
/*
 * constants, frequency lookups and field layout for the loop rate selection registers.
 * assumes a byte wide register port and a single synchronous clock domain.
 */
package prmc_pkg;

    // ========================================================================
    // register map
    localparam logic [6:0] PRMC_ADDR_W = 7'h7F;
    localparam logic [6:0] PRMC_SEC_RATE_ADDR = 7'h64;
    localparam logic [6:0] PRMC_PRI_RATE_ADDR = 7'h65;
    localparam logic [7:0] PRMC_SEC_RATE_RST = 8'h00;
    localparam logic [7:0] PRMC_PRI_RATE_RST = 8'h01;
    localparam logic [7:0] PRMC_SEC_RATE_MASK = 8'h07;
    localparam logic [7:0] PRMC_PRI_RATE_MASK = 8'hF7;

    // ========================================================================
    // field positions
    localparam int PRMC_PHASE_MEAS_BIT = 7;
    localparam int PRMC_A2_SRC_BIT = 6;
    localparam int PRMC_P2A_RATE_HI = 5;
    localparam int PRMC_P2A_RATE_LO = 4;
    localparam int PRMC_RATE_CODE_HI = 2;

    // ========================================================================
    // rate codes
    localparam logic [2:0] PRMC_SEC_SQUELCH = 3'h0;
    localparam logic [2:0] PRMC_SEC_OCN = 3'h1;
    localparam logic [2:0] PRMC_SEC_E3 = 3'h6;
    localparam logic [2:0] PRMC_SEC_DS3 = 3'h7;
    localparam logic [2:0] PRMC_PRI_OCN_DIG = 3'h0;
    localparam logic [2:0] PRMC_PRI_OCN_ANA = 3'h1;
    localparam logic [2:0] PRMC_PRI_FIRST_UNUSED = 3'h6;

    // ========================================================================
    // frequencies in kHz, before the output dividers
    localparam logic [19:0] PRMC_F_OFF = 20'h00000;
    localparam logic [19:0] PRMC_F_77M76 = 20'h12FC0; // 77760 kHz
    localparam logic [19:0] PRMC_F_311M04 = 20'h4BF00; // 311040 kHz
    localparam logic [19:0] PRMC_F_12E1 = 20'h18000; // 98304 kHz
    localparam logic [19:0] PRMC_F_16E1 = 20'h20000; // 131072 kHz
    localparam logic [19:0] PRMC_F_24DS1 = 20'h24300; // 148224 kHz
    localparam logic [19:0] PRMC_F_16DS1 = 20'h18200; // 98816 kHz
    localparam logic [19:0] PRMC_F_E3 = 20'h43200; // 274944 kHz
    localparam logic [19:0] PRMC_F_DS3 = 20'h2BB00; // 178944 kHz

    // e1/ds1 multiple selected by a two-bit index: 12E1, 16E1, 24DS1, 16DS1
    function automatic logic [19:0] prmc_e1ds1_freq(input logic [1:0] idx);
        case (idx)
            2'h0: prmc_e1ds1_freq = PRMC_F_12E1;
            2'h1: prmc_e1ds1_freq = PRMC_F_16E1;
            2'h2: prmc_e1ds1_freq = PRMC_F_24DS1;
            default: prmc_e1ds1_freq = PRMC_F_16DS1;
        endcase
    endfunction : prmc_e1ds1_freq

    // codes 010..101 map onto index 0..3
    function automatic logic [1:0] prmc_code_to_idx(input logic [2:0] code);
        prmc_code_to_idx = 2'(code - 3'h2);
    endfunction : prmc_code_to_idx

endpackage : prmc_pkg

// ---- hdl/prmc_dec_if.sv ----
/*
 * carrier between the register holder and the rate decoder.
 * assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface prmc_dec_if;
    logic [7:0] sec_rate;
    logic [7:0] pri_rate;
    logic sec_run;
    logic phase_measure;
    logic a2_from_primary;
    logic third_loop_bypass;
    logic pri_code_unused;
    logic [19:0] a1_freq_khz;
    logic [19:0] a2_freq_khz;

    modport holder (
        output sec_rate, pri_rate,
        input sec_run, phase_measure, a2_from_primary, third_loop_bypass,
        input pri_code_unused, a1_freq_khz, a2_freq_khz
    );
    modport decoder (
        input sec_rate, pri_rate,
        output sec_run, phase_measure, a2_from_primary, third_loop_bypass,
        output pri_code_unused, a1_freq_khz, a2_freq_khz
    );
endinterface : prmc_dec_if

// ---- hdl/prmc_rate_decode.sv ----
/*
 * combinational decode of the two rate registers into loop modes and frequencies.
 * assumes register values arrive already masked; its outputs are registered by the caller.
 */
`timescale 1ns/1ps
module prmc_rate_decode (
    // register contents in, decoded modes out
    prmc_dec_if.decoder dec
);
    import prmc_pkg::*;

    logic [2:0] sec_code;
    logic [2:0] pri_code;
    logic [1:0] p2a_rate;
    logic [19:0] sec_a2_freq;

    assign sec_code = dec.sec_rate[PRMC_RATE_CODE_HI:0];
    assign pri_code = dec.pri_rate[PRMC_RATE_CODE_HI:0];
    assign p2a_rate = dec.pri_rate[PRMC_P2A_RATE_HI:PRMC_P2A_RATE_LO];

    assign dec.phase_measure = dec.pri_rate[PRMC_PHASE_MEAS_BIT];
    // secondary loop leaves normal operation when squelched or measuring
    assign dec.sec_run = (sec_code != PRMC_SEC_SQUELCH) && !dec.phase_measure;

    always_comb begin
        case (sec_code)
            PRMC_SEC_SQUELCH: sec_a2_freq = PRMC_F_OFF;
            PRMC_SEC_OCN: sec_a2_freq = PRMC_F_311M04;
            PRMC_SEC_E3: sec_a2_freq = PRMC_F_E3;
            PRMC_SEC_DS3: sec_a2_freq = PRMC_F_DS3;
            default: sec_a2_freq = prmc_e1ds1_freq(prmc_code_to_idx(sec_code));
        endcase
    end

    assign dec.a2_from_primary = dec.pri_rate[PRMC_A2_SRC_BIT];
    // primary to second analog rate
    // a squelched or measuring secondary loop turns the second analog loop off unless a2_from_primary is set
    assign dec.a2_freq_khz = dec.a2_from_primary ? prmc_e1ds1_freq(p2a_rate) :
                             (dec.sec_run ? sec_a2_freq : PRMC_F_OFF);

    always_comb begin
        case (pri_code)
            PRMC_PRI_OCN_DIG,
            PRMC_PRI_OCN_ANA: dec.a1_freq_khz = PRMC_F_311M04;
            3'h2, 3'h3, 3'h4, 3'h5: dec.a1_freq_khz = prmc_e1ds1_freq(prmc_code_to_idx(pri_code));
            default: dec.a1_freq_khz = PRMC_F_OFF;
        endcase
    end

    assign dec.third_loop_bypass = (pri_code != PRMC_PRI_OCN_ANA);
    assign dec.pri_code_unused = (pri_code >= PRMC_PRI_FIRST_UNUSED);

endmodule : prmc_rate_decode

// ---- hdl/prmc_top.sv ----
/*
 * loop rate selection registers with decoded, registered mode outputs.
 * assumes the serial configuration port delivers single-cycle read and write strobes
 * with a 7-bit address and byte data, synchronous to i_clk.
 */
`timescale 1ns/1ps
module prmc_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [6:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // decoded loop configuration
    output logic o_sec_run,
    output logic o_phase_measure,
    output logic o_a2_from_primary,
    output logic o_third_loop_bypass,
    output logic o_pri_code_unused,
    output logic [19:0] o_pri_loop_freq_khz,
    output logic [19:0] o_a1_freq_khz,
    output logic [19:0] o_a2_freq_khz
);
    import prmc_pkg::*;

    logic [7:0] sec_rate_q;
    logic [7:0] pri_rate_q;
    logic wr_sec;
    logic wr_pri;

    prmc_dec_if dec_bus ();

    // ========================================================================
    // register writes
    assign wr_sec = i_reg_wr && (i_reg_addr == PRMC_SEC_RATE_ADDR);
    assign wr_pri = i_reg_wr && (i_reg_addr == PRMC_PRI_RATE_ADDR);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sec_rate_q <= PRMC_SEC_RATE_RST;
        end else if (wr_sec) begin
            sec_rate_q <= i_reg_wdata & PRMC_SEC_RATE_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pri_rate_q <= PRMC_PRI_RATE_RST;
        end else if (wr_pri) begin
            pri_rate_q <= i_reg_wdata & PRMC_PRI_RATE_MASK;
        end
    end

    // ========================================================================
    // register reads, one cycle latency; unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    PRMC_SEC_RATE_ADDR: o_reg_rdata <= sec_rate_q;
                    PRMC_PRI_RATE_ADDR: o_reg_rdata <= pri_rate_q;
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ========================================================================
    // decode and output registers
    assign dec_bus.sec_rate = sec_rate_q;
    assign dec_bus.pri_rate = pri_rate_q;

    prmc_rate_decode u_decode (
        .dec(dec_bus.decoder)
    );

    // outputs lag a write by two edges; registering keeps decode glitches off the loops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sec_run <= 1'b0;
            o_phase_measure <= 1'b0;
            o_a2_from_primary <= 1'b0;
            o_third_loop_bypass <= 1'b0;
            o_pri_code_unused <= 1'b0;
            o_a1_freq_khz <= PRMC_F_311M04;
            o_a2_freq_khz <= PRMC_F_OFF;
        end else begin
            o_sec_run <= dec_bus.sec_run;
            o_phase_measure <= dec_bus.phase_measure;
            o_a2_from_primary <= dec_bus.a2_from_primary;
            o_third_loop_bypass <= dec_bus.third_loop_bypass;
            o_pri_code_unused <= dec_bus.pri_code_unused;
            o_a1_freq_khz <= dec_bus.a1_freq_khz;
            o_a2_freq_khz <= dec_bus.a2_freq_khz;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pri_loop_freq_khz <= PRMC_F_77M76;
        end else begin
            o_pri_loop_freq_khz <= PRMC_F_77M76;
        end
    end

    // ========================================================================
    // checks
    sequence s_pri_write(logic [7:0] d);
        wr_pri && i_reg_wdata == d;
    endsequence

    sequence s_pri_stored(logic [7:0] d);
        pri_rate_q == (d & PRMC_PRI_RATE_MASK);
    endsequence

    a_pri_write_mask: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_pri |=> pri_rate_q == ($past(i_reg_wdata) & PRMC_PRI_RATE_MASK))
        else $error("primary rate register did not store masked write");

    a_sec_write_mask: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_sec |=> sec_rate_q[7:3] == 5'h00 && sec_rate_q[2:0] == $past(i_reg_wdata[2:0]))
        else $error("secondary rate register did not store masked write");

    a_meas_stops_sec: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_pri && i_reg_wdata[7]) |-> ##2 (o_phase_measure && !o_sec_run))
        else $error("phase measure did not stop secondary loop");

    a_squelch_off: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_sec && i_reg_wdata[2:0] == 3'h0) ##1 !wr_sec |->
        ##1 (!o_sec_run && (o_a2_from_primary || o_a2_freq_khz == 20'h00000)))
        else $error("squelched secondary loop still running");

    a_sec_ds3_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (sec_rate_q[2:0] == 3'h7 && !pri_rate_q[7] && !pri_rate_q[6]) |->
        ##1 o_a2_freq_khz == PRMC_F_DS3)
        else $error("ds3 secondary rate wrong");

    a_a2_primary_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[6] && pri_rate_q[5:4] == 2'h2) |-> ##1 o_a2_freq_khz == PRMC_F_24DS1)
        else $error("24ds1 rate to second analog loop wrong");

    a_a2_source_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        s_pri_write(8'h41) ##1 !wr_pri |->
        ##1 (o_a2_from_primary && o_a2_freq_khz == PRMC_F_12E1))
        else $error("second analog loop source not primary");

    a_pri_ocn_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[2:1] == 2'h0) |-> ##1 o_a1_freq_khz == PRMC_F_311M04)
        else $error("primary oc-n rate wrong");

    a_bypass_only_001: assert property (@(posedge i_clk) disable iff (i_rst)
        s_pri_write(8'h01) ##1 s_pri_stored(8'h01) |-> ##1 !o_third_loop_bypass)
        else $error("third analog loop bypassed for code 001");

    a_pri_fixed_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_pri_loop_freq_khz == PRMC_F_77M76)
        else $error("primary loop rate moved");

    a_read_returns: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == PRMC_PRI_RATE_ADDR) |=> (o_reg_rvalid && !o_reg_rdata[3]))
        else $error("unused primary bit read nonzero");

    // a ds3 write with a quiet cycle after it, so its decode lands undisturbed
    sequence s_sec_ds3_write;
        (wr_sec && i_reg_wdata[2:0] == PRMC_SEC_DS3) ##1 (!wr_sec && !wr_pri);
    endsequence

    a_ds3_write_runs: assert property (@(posedge i_clk) disable iff (i_rst)
        s_sec_ds3_write |-> ##1 (o_sec_run != o_phase_measure))
        else $error("ds3 write left secondary loop state wrong");

    a_sec_ocn_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (sec_rate_q[2:0] == PRMC_SEC_OCN && pri_rate_q[7:6] == 2'h0) |=>
        o_a2_freq_khz == PRMC_F_311M04)
        else $error("oc-n secondary rate wrong");

    a_sec_e3_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (sec_rate_q[2:0] == PRMC_SEC_E3 && pri_rate_q[7:6] == 2'h0) |=>
        o_a2_freq_khz == PRMC_F_E3)
        else $error("e3 secondary rate wrong");

    a_meas_a2_off: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[7:6] == 2'h2) |=> (o_a2_freq_khz == PRMC_F_OFF && !o_sec_run))
        else $error("measuring secondary loop still feeds second analog loop");

    a_a2_src_flag: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> o_a2_from_primary == $past(pri_rate_q[PRMC_A2_SRC_BIT]))
        else $error("second analog loop source flag wrong");

    a_pri_e1_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[2:0] == 3'h2) |=> o_a1_freq_khz == PRMC_F_12E1)
        else $error("12e1 primary rate wrong");

    a_pri_ds1_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[2:0] == 3'h5) |=> o_a1_freq_khz == PRMC_F_16DS1)
        else $error("16ds1 primary rate wrong");

    a_bypass_others: assert property (@(posedge i_clk) disable iff (i_rst)
        (pri_rate_q[2:0] != PRMC_PRI_OCN_ANA) |=> o_third_loop_bypass)
        else $error("third analog loop kept for a code other than 001");

    a_unmapped_read: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr != PRMC_SEC_RATE_ADDR && i_reg_addr != PRMC_PRI_RATE_ADDR)
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_sec_read_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == PRMC_SEC_RATE_ADDR) |=> o_reg_rdata[7:3] == 5'h00)
        else $error("unused secondary bits read nonzero");

endmodule : prmc_top

// ---- sim/prmc_tb.sv ----
/*
 * self-checking bench for the loop rate selection registers.
 * assumes the strobe-style register port of prmc_top and a 200 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
    import prmc_pkg::*;

    // ========================================================================
    // clock, reset and stimulus
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [6:0] i_reg_addr = 7'h00;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic o_sec_run, o_phase_measure, o_a2_from_primary;
    logic o_third_loop_bypass, o_pri_code_unused;
    logic [19:0] o_pri_loop_freq_khz, o_a1_freq_khz, o_a2_freq_khz;
    int mismatches = 0;
    int comparisons = 0;

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    prmc_top DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_sec_run(o_sec_run),
        .o_phase_measure(o_phase_measure), .o_a2_from_primary(o_a2_from_primary),
        .o_third_loop_bypass(o_third_loop_bypass), .o_pri_code_unused(o_pri_code_unused),
        .o_pri_loop_freq_khz(o_pri_loop_freq_khz), .o_a1_freq_khz(o_a1_freq_khz),
        .o_a2_freq_khz(o_a2_freq_khz)
    );

    // ========================================================================
    // helpers
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk

    // bench-side copy of the e1/ds1 multiple table, kept apart from the design's
    function automatic logic [19:0] mult_khz(input int idx);
        logic [19:0] t [4];
        t = '{PRMC_F_12E1, PRMC_F_16E1, PRMC_F_24DS1, PRMC_F_16DS1};
        return t[idx];
    endfunction : mult_khz

    // one write, then two edges so the decoded outputs have landed
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(posedge i_clk);
        #1 i_reg_wr = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : wr_reg

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(posedge i_clk);
        #1 i_reg_rd = 1'b0;
        chk(20'(o_reg_rvalid), 20'h1, "read valid");
        chk(20'(o_reg_rdata), 20'(exp), "read data");
        // let an edge pass so a following request never re-raises the strobe in this step
        @(posedge i_clk);
        #1;
        chk(20'(o_reg_rvalid), 20'h0, "read valid drops");
    endtask : rd_chk

    // ========================================================================
    // scenarios
    task automatic t_reset;
        rd_chk(PRMC_SEC_RATE_ADDR, 8'h00);
        rd_chk(PRMC_PRI_RATE_ADDR, 8'h01);
        chk(o_a1_freq_khz, PRMC_F_311M04, "reset a1");
        chk(20'(o_sec_run), 20'h0, "reset sec run");
        chk(20'(o_third_loop_bypass), 20'h0, "reset bypass");
        chk(o_pri_loop_freq_khz, PRMC_F_77M76, "primary loop");
        chk(o_a2_freq_khz, PRMC_F_OFF, "reset a2");
        chk(20'(o_phase_measure), 20'h0, "reset phase measure");
        $display("test reset done");
    endtask : t_reset

    task automatic t_secondary;
        logic [19:0] f;
        for (int c = 0; c < 8; c++) begin
            // upper bits set on purpose: they must not stick
            wr_reg(PRMC_SEC_RATE_ADDR, 8'hF8 | 8'(c));
            rd_chk(PRMC_SEC_RATE_ADDR, 8'(c));
            f = (c == 0) ? PRMC_F_OFF : (c == 1) ? PRMC_F_311M04 :
                (c == 6) ? PRMC_F_E3 : (c == 7) ? PRMC_F_DS3 : mult_khz(c - 2);
            chk(o_a2_freq_khz, f, "secondary a2 freq");
            chk(20'(o_sec_run), 20'(c != 0), "secondary run");
            chk(20'(o_a2_from_primary), 20'h0, "a2 source");
        end
        $display("test secondary codes done");
    endtask : t_secondary

    task automatic t_primary;
        // codes 110 and 111 are never written by software
        // bench keeps to codes 000..101
        for (int c = 0; c < 6; c++) begin
            wr_reg(PRMC_PRI_RATE_ADDR, 8'h08 | 8'(c));
            rd_chk(PRMC_PRI_RATE_ADDR, 8'(c));
            chk(o_a1_freq_khz, (c < 2) ? PRMC_F_311M04 : mult_khz(c - 2), "a1 freq");
            chk(20'(o_third_loop_bypass), 20'(c != 1), "third loop bypass");
            chk(o_pri_loop_freq_khz, PRMC_F_77M76, "primary loop rate");
            chk(20'(o_pri_code_unused), 20'h0, "unused flag");
        end
        $display("test primary codes done");
    endtask : t_primary

    task automatic t_a2_source;
        // secondary squelched, so any a2 frequency must come from the primary side
        wr_reg(PRMC_SEC_RATE_ADDR, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr_reg(PRMC_PRI_RATE_ADDR, 8'h41 | 8'(f << 4));
            chk(20'(o_a2_from_primary), 20'h1, "a2 from primary");
            chk(o_a2_freq_khz, mult_khz(f), "primary to a2 rate");
            chk(o_a1_freq_khz, PRMC_F_311M04, "a1 unaffected");
        end
        wr_reg(PRMC_PRI_RATE_ADDR, 8'h31);
        chk(o_a2_freq_khz, PRMC_F_OFF, "a2 back on squelched secondary");
        $display("test a2 source done");
    endtask : t_a2_source

    task automatic t_phase;
        wr_reg(PRMC_SEC_RATE_ADDR, 8'h02);
        wr_reg(PRMC_PRI_RATE_ADDR, 8'h81);
        chk(20'(o_phase_measure), 20'h1, "phase measure on");
        chk(20'(o_sec_run), 20'h0, "secondary out of service");
        chk(o_a2_freq_khz, PRMC_F_OFF, "a2 while measuring");
        wr_reg(PRMC_PRI_RATE_ADDR, 8'h01);
        chk(20'(o_phase_measure), 20'h0, "phase measure off");
        chk(20'(o_sec_run), 20'h1, "secondary back");
        chk(o_a2_freq_khz, PRMC_F_12E1, "a2 from secondary");
        $display("test phase measure done");
    endtask : t_phase

    task automatic t_unmapped;
        wr_reg(7'h66, 8'hFF);
        rd_chk(7'h66, 8'h00);
        rd_chk(PRMC_SEC_RATE_ADDR, 8'h02);
        rd_chk(PRMC_PRI_RATE_ADDR, 8'h01);
        $display("test unmapped done");
    endtask : t_unmapped

    // ========================================================================
    // run control
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (12) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_reset();
        t_secondary();
        t_primary();
        t_a2_source();
        t_phase();
        t_unmapped();
        stop_test();
    end

    // the whole run needs some 120 cycles; this leaves ample margin
    initial begin
        #20us;
        mismatches++;
        stop_test();
    end
endmodule : testbench
